// >>> core/nfs_pkg.sv
// Purpose: Shared constants, encodings and helpers for the erase host.
// Assumes: 250 MHz clock, 16-bit flash data bus, 24-bit word address.
// Notes:   Pin timing figures are plain defaults; tune them per part.
package nfs_pkg;

	localparam int unsigned CLK_NS = 4;

	function automatic int unsigned nfs_cyc_up(input int unsigned ns);
		return (ns + CLK_NS - 1) / CLK_NS;
	endfunction

	function automatic int unsigned nfs_cyc_dn(input int unsigned ns);
		return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
	endfunction

	localparam int unsigned T_SETUP_NS   = 10;
	localparam int unsigned T_SETUP_CYC  = nfs_cyc_up(T_SETUP_NS);
	localparam int unsigned T_WP_NS      = 40;
	localparam int unsigned T_WP_CYC     = nfs_cyc_up(T_WP_NS);
	localparam int unsigned T_ACC_NS     = 80;
	localparam int unsigned T_ACC_CYC    = nfs_cyc_up(T_ACC_NS);
	localparam int unsigned T_HOLD_NS    = 20;
	localparam int unsigned T_HOLD_CYC   = nfs_cyc_up(T_HOLD_NS);
	localparam int unsigned T_RP_NS      = 500;
	localparam int unsigned T_RP_CYC     = nfs_cyc_up(T_RP_NS);
	localparam int unsigned SUSP_LAT_NS  = 30000;
	localparam int unsigned SUSP_LAT_CYC = nfs_cyc_up(SUSP_LAT_NS);
	localparam int unsigned BLK_WIN_NS   = 50000;
	localparam int unsigned BLK_WIN_CYC  = nfs_cyc_dn(BLK_WIN_NS);
	localparam int unsigned SYNC_STAGES  = 2;

	localparam int unsigned ADDR_W = 24;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned CNT_W  = 16;
	localparam int unsigned BANK_HI = 23;
	localparam int unsigned BANK_LO = 22;

	localparam logic [23:0] UNLK_A1   = 24'h000555;
	localparam logic [23:0] UNLK_A2   = 24'h0002AA;
	localparam logic [15:0] D_UNLK1   = 16'h00AA;
	localparam logic [15:0] D_UNLK2   = 16'h0055;
	localparam logic [15:0] D_SETUP   = 16'h0080;
	localparam logic [15:0] D_CHIP    = 16'h0010;
	localparam logic [15:0] D_BLOCK   = 16'h0030;
	localparam logic [15:0] D_SUSPEND = 16'h00B0;
	localparam logic [15:0] D_RESUME  = 16'h0030;
	localparam logic [15:0] D_RESET   = 16'h00F0;
	localparam logic [15:0] D_AUTOSEL = 16'h0090;
	localparam logic [15:0] D_EXT_IN  = 16'h0088;
	localparam logic [15:0] D_EXT_OUT = 16'h0090;
	localparam logic [15:0] D_EXT_END = 16'h0000;

	localparam logic [3:0] OP_READ    = 4'h0;
	localparam logic [3:0] OP_CHIP    = 4'h1;
	localparam logic [3:0] OP_BLOCK   = 4'h2;
	localparam logic [3:0] OP_ADD     = 4'h3;
	localparam logic [3:0] OP_SUSPEND = 4'h4;
	localparam logic [3:0] OP_RESUME  = 4'h5;
	localparam logic [3:0] OP_RESET   = 4'h6;
	localparam logic [3:0] OP_AUTOSEL = 4'h7;
	localparam logic [3:0] OP_EXT_IN  = 4'h8;
	localparam logic [3:0] OP_EXT_OUT = 4'h9;
	localparam logic [3:0] OP_HWRESET = 4'hA;

	localparam logic [2:0] SQ_ONE   = 3'h0;
	localparam logic [2:0] SQ_CHIP6 = 3'h1;
	localparam logic [2:0] SQ_BLK6  = 3'h2;
	localparam logic [2:0] SQ_CHIP2 = 3'h3;
	localparam logic [2:0] SQ_BLK2  = 3'h4;
	localparam logic [2:0] SQ_UNLK3 = 3'h5;
	localparam logic [2:0] SQ_EXT4  = 3'h6;

	function automatic logic [2:0] nfs_len(input logic [2:0] kind);
		case (kind)
			SQ_CHIP6, SQ_BLK6: return 3'h6;
			SQ_CHIP2, SQ_BLK2: return 3'h2;
			SQ_UNLK3:          return 3'h3;
			SQ_EXT4:           return 3'h4;
			default:           return 3'h1;
		endcase
	endfunction

	// Returns {address, data} of write cycle idx of a sequence
	function automatic logic [39:0] nfs_step(input logic [2:0] kind,
			input logic [2:0] idx, input logic [23:0] tgt,
			input logic [15:0] od);
		logic last;
		last = (idx == nfs_len(kind) - 3'h1);
		if (kind == SQ_ONE)
			return {tgt, od};
		else if (kind == SQ_CHIP2 || kind == SQ_BLK2)
			return last ? {tgt, od} : {UNLK_A1, D_SETUP};
		else if (kind == SQ_EXT4 && idx == 3'h3)
			return {UNLK_A1, D_EXT_END};
		else if (idx == 3'h0 || idx == 3'h3)
			return {UNLK_A1, D_UNLK1};
		else if (idx == 3'h1 || idx == 3'h4)
			return {UNLK_A2, D_UNLK2};
		else if (kind == SQ_UNLK3 || kind == SQ_EXT4)
			return {UNLK_A1, od};
		else if (idx == 3'h2)
			return {UNLK_A1, D_SETUP};
		else
			return {tgt, od};
	endfunction

	function automatic logic [3:0] nfs_bank(input logic [23:0] a);
		return 4'h1 << a[BANK_HI:BANK_LO];
	endfunction

endpackage

// >>> core/nfs_bus_cycle.sv
// Purpose: One asynchronous flash bus write or read cycle per request.
// Assumes: Write cycles are WE-controlled with CE held low throughout.
// Notes:   Read data passes two sync stages, so access time grows by two.
`timescale 1ns/1ps
`default_nettype none
module nfs_bus_cycle
	import nfs_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        req,
	input  wire logic        wr,
	input  wire logic [23:0] addr,
	input  wire logic [15:0] wdata,
	output logic             done,
	output logic [15:0]      rdata,
	output logic [23:0]      flash_addr,
	output logic [15:0]      flash_dq_out,
	output logic             flash_dq_oe_n,
	input  wire logic [15:0] flash_dq_in,
	output logic             flash_ce_n,
	output logic             flash_we_n,
	output logic             flash_oe_n
);

	typedef enum logic [3:0] {
		E_IDLE  = 4'h1,
		E_SETUP = 4'h2,
		E_ACT   = 4'h4,
		E_HOLD  = 4'h8
	} nfs_eng_st_t;

	typedef struct packed {
		nfs_eng_st_t st;
		logic [7:0]  cnt;
		logic        wr;
		logic [23:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic        done;
		logic [15:0] s1;
		logic [15:0] s2;
	} nfs_eng_t;

	nfs_eng_t r, n;

	always_comb begin
		n = r;
		n.done = 1'b0;
		n.s1 = flash_dq_in;
		n.s2 = r.s1;
		if (r.cnt != 8'h00)
			n.cnt = r.cnt - 8'h01;
		case (r.st)
			E_IDLE: if (req) begin
				n.st = E_SETUP;
				n.wr = wr;
				n.addr = addr;
				n.wdata = wdata;
				n.cnt = 8'(T_SETUP_CYC - 1);
			end
			E_SETUP: if (r.cnt == 8'h00) begin
				n.st = E_ACT;
				// Read window covers the pin sync delay too
				n.cnt = r.wr ? 8'(T_WP_CYC - 1)
					: 8'(T_ACC_CYC + SYNC_STAGES - 1);
			end
			E_ACT: if (r.cnt == 8'h00) begin
				n.st = E_HOLD;
				n.cnt = 8'(T_HOLD_CYC - 1);
				if (!r.wr)
					n.rdata = r.s2;
			end
			E_HOLD: if (r.cnt == 8'h00) begin
				n.st = E_IDLE;
				n.done = 1'b1;
			end
			default: n.st = E_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			r <= '{st: E_IDLE, default: '0};
		else
			r <= n;
	end

	assign done          = r.done;
	assign rdata         = r.rdata;
	assign flash_addr    = r.addr;
	assign flash_dq_out  = r.wdata;
	assign flash_dq_oe_n = !(r.wr && r.st != E_IDLE);
	assign flash_ce_n    = (r.st == E_IDLE);
	assign flash_we_n    = !(r.wr && r.st == E_ACT);
	assign flash_oe_n    = !(!r.wr && r.st == E_ACT);

endmodule
`default_nettype wire

// >>> core/nfs_erase_host.sv
// Purpose: Host-side erase sequencer driving a parallel NOR flash.
// Assumes: User logic polls status via reads and reports completion.
// Notes:   Commands the flash would ignore are dropped here with a reject.
`timescale 1ns/1ps
`default_nettype none
module nfs_erase_host
	import nfs_pkg::*;
#(
	parameter int unsigned WIN_CYC = BLK_WIN_CYC,
	parameter int unsigned LAT_CYC = SUSP_LAT_CYC
)(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [3:0]  cmd_op,
	input  wire logic [23:0] cmd_addr,
	input  wire logic        cmd_bypass,
	output logic             cmd_reject,
	input  wire logic        erase_done,
	input  wire logic        erase_fail,
	output logic             rsp_valid,
	output logic [15:0]      rsp_data,
	output logic             rsp_is_status,
	output logic             erasing,
	output logic             suspended,
	output logic             error,
	output logic             redo_erase,
	output logic             window_open,
	output logic [23:0]      flash_addr,
	output logic [15:0]      flash_dq_out,
	output logic             flash_dq_oe_n,
	input  wire logic [15:0] flash_dq_in,
	output logic             flash_ce_n,
	output logic             flash_we_n,
	output logic             flash_oe_n,
	output logic             flash_rst_n
);

	typedef enum logic [2:0] {
		M_IDLE  = 3'h1,
		M_ISSUE = 3'h2,
		M_WAIT  = 3'h4
	} nfs_seq_st_t;

	typedef enum logic [5:0] {
		MD_READY = 6'h01,
		MD_CHIP  = 6'h02,
		MD_BLOCK = 6'h04,
		MD_SUSPG = 6'h08,
		MD_SUSPD = 6'h10,
		MD_ERROR = 6'h20
	} nfs_mode_t;

	typedef struct packed {
		nfs_seq_st_t st;
		nfs_mode_t   md;
		logic [2:0]  kind;
		logic [2:0]  idx;
		logic [23:0] tgt;
		logic [15:0] od;
		logic        rd;
		logic        rdst;
		logic        arm;
		logic [15:0] win;
		logic [15:0] lat;
		logic [15:0] rstp;
		logic        autosel;
		logic        extblk;
		logic [3:0]  banks;
		logic        redo;
		logic        rsp_v;
		logic        rsp_st;
		logic [15:0] rsp_d;
		logic        rej;
	} nfs_host_t;

	nfs_host_t   r, n;
	nfs_host_t   keep;
	logic        accept;
	logic        ok;
	logic        eng_req;
	logic        eng_done;
	logic [15:0] eng_rdata;
	logic [39:0] step;
	logic        in_bank;

	assign cmd_ready = (r.st == M_IDLE) && (r.rstp == 16'h0000);
	assign accept    = cmd_valid && cmd_ready;
	assign step      = nfs_step(r.kind, r.idx, r.tgt, r.od);
	assign in_bank   = |(nfs_bank(cmd_addr) & r.banks);

	always_comb begin
		n = r;
		ok = 1'b1;
		eng_req = 1'b0;
		n.rsp_v = 1'b0;
		n.rej = 1'b0;
		if (r.win != 16'h0000)
			n.win = r.win - 16'h0001;
		if (r.rstp != 16'h0000)
			n.rstp = r.rstp - 16'h0001;
		if (r.md == MD_SUSPG) begin
			if (r.lat == 16'h0000)
				n.md = MD_SUSPD;
			else
				n.lat = r.lat - 16'h0001;
		end
		// Completion counts only once the controller has started
		if (erase_done && (r.md == MD_CHIP
				|| (r.md == MD_BLOCK && r.win == 16'h0000)))
			n.md = erase_fail ? MD_ERROR : MD_READY;
		keep = n;
		case (r.st)
			M_IDLE: if (accept) begin
				n.tgt = cmd_addr;
				n.idx = 3'h0;
				n.kind = SQ_ONE;
				n.rd = 1'b0;
				n.arm = 1'b0;
				n.rdst = 1'b0;
				case (cmd_op)
					OP_READ: begin
						n.rd = 1'b1;
						case (r.md)
							MD_CHIP, MD_ERROR: n.rdst = 1'b1;
							MD_BLOCK, MD_SUSPG: n.rdst = in_bank;
							MD_SUSPD: n.rdst = in_bank && !r.extblk;
							default: n.rdst = 1'b0;
						endcase
					end
					OP_CHIP, OP_BLOCK: begin
						ok = (r.md == MD_READY) && !r.autosel && !r.extblk;
						n.kind = (cmd_op == OP_CHIP)
							? (cmd_bypass ? SQ_CHIP2 : SQ_CHIP6)
							: (cmd_bypass ? SQ_BLK2 : SQ_BLK6);
						n.od = (cmd_op == OP_CHIP) ? D_CHIP : D_BLOCK;
						n.arm = (cmd_op == OP_BLOCK);
						n.md = (cmd_op == OP_CHIP) ? MD_CHIP : MD_BLOCK;
						n.banks = nfs_bank(cmd_addr);
						n.redo = 1'b0;
					end
					OP_ADD: begin
						ok = (r.md == MD_BLOCK) && (r.win != 16'h0000);
						n.od = D_BLOCK;
						n.arm = 1'b1;
						n.banks = r.banks | nfs_bank(cmd_addr);
					end
					OP_SUSPEND: begin
						ok = (r.md == MD_BLOCK);
						n.od = D_SUSPEND;
						n.md = MD_SUSPG;
						n.win = 16'h0000;
						n.lat = 16'(LAT_CYC);
					end
					OP_RESUME: begin
						ok = (r.md == MD_SUSPD) && !r.autosel
							&& !r.extblk;
						n.od = D_RESUME;
						n.md = MD_BLOCK;
					end
					OP_RESET: begin
						ok = (r.md == MD_READY) || (r.md == MD_ERROR)
							|| (r.md == MD_SUSPD)
							|| (r.md == MD_BLOCK && r.win != 16'h0000);
						n.od = D_RESET;
						n.autosel = 1'b0;
						if (r.md != MD_SUSPD) begin
							n.md = MD_READY;
							n.win = 16'h0000;
						end
					end
					OP_AUTOSEL, OP_EXT_IN: begin
						ok = (r.md == MD_READY || r.md == MD_SUSPD)
							&& !r.extblk;
						n.kind = SQ_UNLK3;
						n.od = (cmd_op == OP_AUTOSEL) ? D_AUTOSEL : D_EXT_IN;
						n.autosel = (cmd_op == OP_AUTOSEL) || r.autosel;
						n.extblk = (cmd_op == OP_EXT_IN);
					end
					OP_EXT_OUT: begin
						ok = r.extblk;
						n.kind = SQ_EXT4;
						n.od = D_EXT_OUT;
						n.extblk = 1'b0;
					end
					OP_HWRESET: begin
						ok = 1'b0;
						n.rstp = 16'(T_RP_CYC);
						// Aborted erase leaves data undefined
						n.redo = (r.md != MD_READY);
						n.md = MD_READY;
						n.win = 16'h0000;
						n.autosel = 1'b0;
						n.extblk = 1'b0;
					end
					default: ok = 1'b0;
				endcase
				if (ok) begin
					n.st = M_ISSUE;
				end else if (cmd_op != OP_HWRESET) begin
					// Refusal must not swallow a completion or stall timers
					n = keep;
					n.rej = 1'b1;
				end
			end
			M_ISSUE: begin
				eng_req = 1'b1;
				n.st = M_WAIT;
			end
			M_WAIT: if (eng_done) begin
				if (r.rd) begin
					n.st = M_IDLE;
					n.rsp_v = 1'b1;
					n.rsp_d = eng_rdata;
					n.rsp_st = r.rdst;
				end else if (r.idx == nfs_len(r.kind) - 3'h1) begin
					n.st = M_IDLE;
					if (r.arm)
						n.win = 16'(WIN_CYC);
				end else begin
					n.idx = r.idx + 3'h1;
					n.st = M_ISSUE;
				end
			end
			default: n.st = M_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			r <= '{st: M_IDLE, md: MD_READY, default: '0};
		else
			r <= n;
	end

	nfs_bus_cycle u_cycle (
		.clk           (clk),
		.reset_n       (reset_n),
		.req           (eng_req),
		.wr            (!r.rd),
		.addr          (step[39:16]),
		.wdata         (step[15:0]),
		.done          (eng_done),
		.rdata         (eng_rdata),
		.flash_addr    (flash_addr),
		.flash_dq_out  (flash_dq_out),
		.flash_dq_oe_n (flash_dq_oe_n),
		.flash_dq_in   (flash_dq_in),
		.flash_ce_n    (flash_ce_n),
		.flash_we_n    (flash_we_n),
		.flash_oe_n    (flash_oe_n)
	);

	assign cmd_reject    = r.rej;
	assign rsp_valid     = r.rsp_v;
	assign rsp_data      = r.rsp_d;
	assign rsp_is_status = r.rsp_st;
	assign erasing       = (r.md == MD_CHIP) || (r.md == MD_BLOCK);
	assign suspended     = (r.md == MD_SUSPD);
	assign error         = (r.md == MD_ERROR);
	assign redo_erase    = r.redo;
	assign window_open   = (r.md == MD_BLOCK) && (r.win != 16'h0000);
	assign flash_rst_n   = (r.rstp == 16'h0000);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	chk_chip_no_suspend: assert property (accept && cmd_op == OP_SUSPEND
		&& r.md == MD_CHIP |=> cmd_reject)
		else $error("suspend taken during chip erase");
	chk_chip_read_status: assert property (accept && cmd_op == OP_READ
		&& r.md == MD_CHIP |-> ##[1:80] (rsp_valid && rsp_is_status))
		else $error("chip erase read not flagged as status");
	chk_fail_holds: assert property (r.md == MD_CHIP && erase_done
		&& erase_fail |=> error && !erasing)
		else $error("erase failure not held");
	chk_chip_last_write: assert property (eng_req && r.kind == SQ_CHIP6
		&& r.idx == 3'h5 |-> ##[1:20] (!flash_we_n
		&& flash_dq_out == D_CHIP))
		else $error("chip erase last write wrong");
	chk_bypass_blk_write: assert property (eng_req && r.kind == SQ_BLK2
		&& r.idx == 3'h1 |-> ##[1:20] (!flash_we_n
		&& flash_addr == r.tgt && flash_dq_out == D_BLOCK))
		else $error("bypass block write wrong");
	chk_add_closed: assert property (accept && cmd_op == OP_ADD
		&& r.win == 16'h0000 |=> cmd_reject)
		else $error("block added after window");
	chk_reset_in_block: assert property (accept && cmd_op == OP_RESET
		&& r.md == MD_BLOCK && r.win == 16'h0000 |=> cmd_reject)
		else $error("reset taken in running block erase");
	chk_suspend_window: assert property (accept && cmd_op == OP_SUSPEND
		&& r.md == MD_BLOCK |=> !window_open && !suspended
		&& r.md == MD_SUSPG)
		else $error("suspend did not end window");
	chk_resume_autosel: assert property (accept && cmd_op == OP_RESUME
		&& (r.autosel || r.extblk) |=> cmd_reject)
		else $error("resume taken outside read mode");
	chk_hwreset_redo: assert property (accept && cmd_op == OP_HWRESET
		&& r.md == MD_CHIP |=> redo_erase && !flash_rst_n)
		else $error("reset abort not reported");

	cov_chip: cover property (accept && cmd_op == OP_CHIP);
	cov_add: cover property (accept && cmd_op == OP_ADD && window_open);
	cov_suspend: cover property (r.md == MD_SUSPG ##1 r.md == MD_SUSPD);
	cov_resume: cover property (accept && cmd_op == OP_RESUME
		&& suspended);

endmodule
`default_nettype wire

// >>> bench/nfs_flash_model.sv
// Purpose: Behavioural flash device for the erase host bench.
// Assumes: Writes latch on the rising edge of WE with CE low.
// Notes:   Erase completes only when op_end pulses; failures are never flagged.
`timescale 1ns/1ps
`default_nettype none
module nfs_flash_model
	import nfs_pkg::*;
#(
	parameter logic [15:0] STAT = 16'h00C4,
	parameter logic [3:0]  PROT = 4'h8
)(
	input  wire logic [23:0] flash_addr,
	input  wire logic [15:0] flash_dq_out,
	input  wire logic        flash_ce_n,
	input  wire logic        flash_we_n,
	input  wire logic        flash_oe_n,
	input  wire logic        flash_rst_n,
	input  wire logic        op_end,
	output logic [15:0]      flash_dq_in
);
	logic [23:0] la [0:63];
	logic [15:0] ld [0:63];
	int          n = 0;
	// Mode: 0 read, 1 chip erase, 2 block erase, 3 suspended
	logic [1:0]  md = 2'h0;
	logic [3:0]  bm = 4'h0;
	logic [3:0]  ers = 4'h0;
	logic        su = 1'b0;
	logic [15:0] lq = 16'h0000;
	logic [15:0] rv;
	logic [15:0] d;
	logic [3:0]  bk;
	assign d = flash_dq_out;
	assign bk = 4'h1 << flash_addr[23:22];
	// Erased banks read all ones; protected banks keep their contents
	assign rv = (md != 2'h0 && |(bm & bk)) ? STAT :
		|(ers & bk) ? 16'hFFFF : flash_addr[15:0] ^ 16'hA5A5;
	// Released bus shows the inverse of the last word, not a stale copy
	assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rv : ~lq;
	always @(posedge flash_oe_n) lq <= rv;
	always @(posedge flash_we_n or negedge flash_rst_n or posedge op_end) begin
		if (!flash_rst_n || op_end) begin
			md <= 2'h0;
			bm <= 4'h0;
			if (op_end)
				ers <= ers | (bm & ~PROT);
		end else if (!flash_ce_n) begin
			la[n[5:0]] <= flash_addr;
			ld[n[5:0]] <= d;
			n <= n + 1;
			// Setup code stays armed across the second unlock pair
			su <= (d == D_SETUP) || (su && (d == D_UNLK1 || d == D_UNLK2));
			if (su && d == D_CHIP) begin
				md <= 2'h1;
				bm <= 4'hF;
			end else if (su && d == D_BLOCK) begin
				md <= 2'h2;
				bm <= bm | bk;
			end else if (md == 2'h2 && d == D_BLOCK) begin
				bm <= bm | bk;
			end else if (md == 2'h2 && d == D_SUSPEND) begin
				md <= 2'h3;
			end else if (md == 2'h3 && d == D_RESUME) begin
				md <= 2'h2;
			end else if (md != 2'h3 && d == D_RESET) begin
				md <= 2'h0;
				bm <= 4'h0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> bench/tb_nfs_erase_host.sv
// Purpose: Self-checking bench for the erase host sequencer.
// Assumes: Short window and latency values keep the run brief.
// Notes:   Erase completion is reported by pulsing erase_done by hand.
`timescale 1ns/1ps
`default_nettype none
module tb_nfs_erase_host import nfs_pkg::*;;
	localparam logic [15:0] STAT = 16'h00C4;
	localparam logic [3:0]  PROT = 4'h8;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        cmd_valid = 1'b0;
	logic [3:0]  cmd_op = 4'h0;
	logic [23:0] cmd_addr = 24'h000000;
	logic        cmd_bypass = 1'b0;
	logic        erase_done = 1'b0;
	logic        erase_fail = 1'b0;
	logic        op_end = 1'b0;
	logic        cmd_ready, cmd_reject, rsp_valid, rsp_is_status;
	logic        erasing, suspended, error, redo_erase, window_open;
	logic [15:0] rsp_data, flash_dq_out, flash_dq_in;
	logic [23:0] flash_addr;
	logic        flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n;
	logic        flash_rst_n;
	int          error_cnt = 0;
	int          checks = 0;
	int          base = 0;
	logic [3:0]  ers_exp = 4'h0;
	logic [23:0] rlow;
	logic [15:0] rd;
	logic        rs;
	always #2 clk = ~clk;
	nfs_erase_host #(.WIN_CYC(40), .LAT_CYC(10)) nfs_erase_host_inst (
		.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_bypass(cmd_bypass), .cmd_reject(cmd_reject),
		.erase_done(erase_done), .erase_fail(erase_fail),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_is_status(rsp_is_status), .erasing(erasing),
		.suspended(suspended), .error(error), .redo_erase(redo_erase),
		.window_open(window_open), .flash_addr(flash_addr),
		.flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
		.flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
		.flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
		.flash_rst_n(flash_rst_n));
	nfs_flash_model #(.STAT(STAT), .PROT(PROT)) nfs_flash_model_inst (
		.flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
		.flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
		.flash_oe_n(flash_oe_n), .flash_rst_n(flash_rst_n),
		.op_end(op_end), .flash_dq_in(flash_dq_in));
	task automatic tally_and_finish();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [23:0] e,
			input logic [23:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkb(input string nm, input logic e, input logic g);
		chk(nm, {23'h0, e}, {23'h0, g});
	endtask
	// Offer one command, then collect reject, read data and reset pulse
	task automatic issue(input logic [3:0] op, input logic [23:0] a,
			input logic by, input logic rej);
		logic seen;
		int   i;
		seen = 1'b0;
		rlow = 24'h0;
		for (i = 0; i < 1000 && cmd_ready !== 1'b1; i++) @(negedge clk);
		if (i >= 1000) begin
			error_cnt++;
			tally_and_finish();
		end
		base = nfs_flash_model_inst.n;
		cmd_op = op;
		cmd_addr = a;
		cmd_bypass = by;
		cmd_valid = 1'b1;
		for (i = 0; i < 1000; i++) begin
			@(negedge clk);
			cmd_valid = 1'b0;
			seen |= (cmd_reject === 1'b1);
			if (rsp_valid === 1'b1) begin
				rd = rsp_data;
				rs = rsp_is_status;
			end
			if (flash_rst_n === 1'b0) rlow++;
			if (i >= 3 && cmd_ready === 1'b1) break;
		end
		if (i >= 1000) begin
			error_cnt++;
			tally_and_finish();
		end
		chkb("cmd_reject", rej, seen);
		if (rej) chk("wr_count", 24'h0, 24'(nfs_flash_model_inst.n - base));
	endtask
	task automatic wr(input int k, input logic [23:0] a, input logic [15:0] d);
		chk("wr_addr", a, nfs_flash_model_inst.la[base + k]);
		chk("wr_data", {8'h0, d}, {8'h0, nfs_flash_model_inst.ld[base + k]});
	endtask
	task automatic unl6(input logic [23:0] t, input logic [15:0] d);
		chk("wr_count", 24'h6, 24'(nfs_flash_model_inst.n - base));
		wr(0, UNLK_A1, D_UNLK1);
		wr(1, UNLK_A2, D_UNLK2);
		wr(2, UNLK_A1, D_SETUP);
		wr(3, UNLK_A1, D_UNLK1);
		wr(4, UNLK_A2, D_UNLK2);
		wr(5, t, d);
	endtask
	task automatic rdchk(input logic [23:0] a, input logic st);
		issue(OP_READ, a, 1'b0, 1'b0);
		chkb("rsp_is_status", st, rs);
		chk("rsp_data", {8'h0, st ? STAT
			: |(ers_exp & (4'h1 << a[23:22])) ? 16'hFFFF
			: a[15:0] ^ 16'hA5A5}, {8'h0, rd});
	endtask
	task automatic fin(input logic f, input logic [3:0] m);
		@(negedge clk);
		if (!f)
			ers_exp |= m & ~PROT;
		erase_done = 1'b1;
		erase_fail = f;
		op_end = !f;
		@(negedge clk);
		erase_done = 1'b0;
		erase_fail = 1'b0;
		op_end = 1'b0;
	endtask
	task automatic s_chip();
		issue(OP_CHIP, UNLK_A1, 1'b0, 1'b0);
		unl6(UNLK_A1, D_CHIP);
		chkb("erasing", 1'b1, erasing);
		issue(OP_SUSPEND, 24'h400000, 1'b0, 1'b1);
		issue(OP_RESET, 24'h400000, 1'b0, 1'b1);
		issue(OP_BLOCK, 24'h400000, 1'b0, 1'b1);
		rdchk(24'h401234, 1'b1);
		fin(1'b1, 4'hF);
		chkb("error", 1'b1, error);
		rdchk(24'h002222, 1'b1);
		issue(OP_RESET, 24'h000000, 1'b0, 1'b0);
		wr(0, 24'h000000, D_RESET);
		chkb("error", 1'b0, error);
		rdchk(24'h002222, 1'b0);
		issue(4'hF, 24'h000000, 1'b0, 1'b1);
		issue(OP_CHIP, 24'h000000, 1'b1, 1'b0);
		chk("wr_count", 24'h2, 24'(nfs_flash_model_inst.n - base));
		wr(0, UNLK_A1, D_SETUP);
		wr(1, 24'h000000, D_CHIP);
		issue(OP_SUSPEND, 24'h000000, 1'b0, 1'b1);
		fin(1'b0, 4'hF);
		chkb("erasing", 1'b0, erasing);
		rdchk(24'h002222, 1'b0);
		rdchk(24'hC00100, 1'b0);
	endtask
	task automatic s_block();
		int i;
		issue(OP_BLOCK, 24'h412340, 1'b0, 1'b0);
		unl6(24'h412340, D_BLOCK);
		chkb("window_open", 1'b1, window_open);
		repeat (25) @(negedge clk);
		issue(OP_ADD, 24'hC00000, 1'b0, 1'b0);
		wr(0, 24'hC00000, D_BLOCK);
		chkb("window_open", 1'b1, window_open);
		rdchk(24'h400100, 1'b1);
		rdchk(24'hC00100, 1'b1);
		rdchk(24'h001234, 1'b0);
		repeat (45) @(negedge clk);
		chkb("window_open", 1'b0, window_open);
		issue(OP_ADD, 24'h800000, 1'b0, 1'b1);
		issue(OP_RESET, 24'h400000, 1'b0, 1'b1);
		issue(OP_CHIP, 24'h400000, 1'b0, 1'b1);
		for (int k = 0; k < 2; k++) begin
			issue(OP_SUSPEND, 24'h412340, 1'b0, 1'b0);
			wr(0, 24'h412340, D_SUSPEND);
			for (i = 0; i < 12 && suspended !== 1'b1; i++) @(negedge clk);
			chkb("suspended", 1'b1, suspended);
			rdchk(24'h400200, 1'b1);
			rdchk(24'h801000, 1'b0);
			issue(k ? OP_EXT_IN : OP_AUTOSEL, UNLK_A1, 1'b0, 1'b0);
			issue(OP_RESUME, 24'h412340, 1'b0, 1'b1);
			issue(k ? OP_EXT_OUT : OP_RESET, UNLK_A1, 1'b0, 1'b0);
			issue(OP_RESUME, 24'h412340, 1'b0, 1'b0);
			wr(0, 24'h412340, D_RESUME);
			chkb("suspended", 1'b0, suspended);
		end
		fin(1'b0, 4'hA);
		chkb("erasing", 1'b0, erasing);
		rdchk(24'hC00200, 1'b0);
	endtask
	task automatic s_bypass_reset();
		issue(OP_BLOCK, 24'h800000, 1'b1, 1'b0);
		wr(0, UNLK_A1, D_SETUP);
		wr(1, 24'h800000, D_BLOCK);
		issue(OP_ADD, 24'h810000, 1'b0, 1'b0);
		wr(0, 24'h810000, D_BLOCK);
		issue(OP_RESET, 24'h800000, 1'b0, 1'b0);
		wr(0, 24'h800000, D_RESET);
		chkb("erasing", 1'b0, erasing);
	endtask
	task automatic s_hwreset();
		issue(OP_CHIP, 24'h000000, 1'b1, 1'b0);
		issue(OP_HWRESET, 24'h000000, 1'b0, 1'b0);
		chk("rst_cycles", 24'(T_RP_CYC), rlow);
		chkb("redo_erase", 1'b1, redo_erase);
		chkb("erasing", 1'b0, erasing);
		issue(OP_CHIP, UNLK_A1, 1'b0, 1'b0);
		chkb("redo_erase", 1'b0, redo_erase);
		fin(1'b0, 4'hF);
	endtask
	initial begin
		repeat (12) @(negedge clk);
		reset_n = 1'b1;
		s_chip();
		s_block();
		s_bypass_reset();
		s_hwreset();
		tally_and_finish();
	end
endmodule
`default_nettype wire
